// ==== verilog/tlic_ctrl.sv ====
// Two-level interrupt controller top: flags, enables, levels, vector calls.
// Assumes a core that pulses instruction-done at each boundary and flags
// the boundary of a return instruction; source events are on this clock.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tlic_ctrl #(
    parameter int N_SRC = tlic_pkg::NSRC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [N_SRC-1:0] SRC_SET_I,
    input wire logic [1:0] EXT_INT_N_I,
    input wire logic CORE_INSTR_DONE_I,
    input wire logic CORE_RETURN_FROM_INTERRUPT_I,
    output logic CALL_O,
    output logic [tlic_pkg::VEC_W-1:0] VECTOR_O,
    output logic IRQ_O
);
    import tlic_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode

    logic wb_hit; // A request is on the bus
    logic wr_fire; // Write takes effect at this edge
    logic rd_fire; // Read data is taken at this edge
    logic [15:0] bmask; // Byte lanes selected by the master
    logic global_irq_enable_q; // Master gate for every source
    logic [N_SRC-1:0] irq_enable_reg_q; // Per-source enables
    logic [N_SRC-1:0] irq_priority_reg_q; // Per-source level, 1 = high
    logic [N_SRC-1:0] pend_q; // Pending flags
    logic [N_SRC-1:0] req_q; // Eligible requests, sampled each cycle
    logic [1:0] insvc_q; // In-service marker per level
    logic [2:0] stat_q; // Sticky event bits
    logic [2:0] mask_q; // Event mask

    assign wb_hit = WB_CYC_I & WB_STB_I;
    // Writes land on the edge the master sees ack, never earlier
    assign wr_fire = wb_hit & WB_WE_I & WB_ACK_O;
    assign rd_fire = wb_hit & ~WB_WE_I & WB_ACK_O;
    assign bmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    // Merge selected byte lanes of the write data into a source-wide value
    function automatic logic [N_SRC-1:0] merge(input logic [N_SRC-1:0] old);
        logic [15:0] o16;
        o16 = 16'(old);
        o16 = (o16 & ~bmask) | (WB_DAT_I[15:0] & bmask);
        return o16[N_SRC-1:0];
    endfunction

    // Trade-off: one wait state on every access buys registered read data
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_hit & ~WB_ACK_O;
        end
    end

    // Read data is captured as ack rises; unmapped offsets read zero
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (wb_hit && !WB_ACK_O) begin
            unique case (WB_ADR_I)
                ADR_CTRL: WB_DAT_O <= 32'(global_irq_enable_q);
                ADR_EN: WB_DAT_O <= 32'(irq_enable_reg_q);
                ADR_PRIO: WB_DAT_O <= 32'(irq_priority_reg_q);
                ADR_PEND: WB_DAT_O <= 32'(pend_q);
                ADR_SVC: WB_DAT_O <= 32'(insvc_q);
                ADR_STAT: WB_DAT_O <= 32'(stat_q);
                ADR_MASK: WB_DAT_O <= 32'(mask_q);
                ADR_REQ: WB_DAT_O <= 32'(req_q);
                default: WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Enables, levels, mask: plain software storage
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            global_irq_enable_q <= 1'b0;
            irq_enable_reg_q <= EN_RST[N_SRC-1:0];
            irq_priority_reg_q <= PRIO_RST[N_SRC-1:0]; // RL11
            mask_q <= MASK_RST;
        end else if (wr_fire) begin
            if (WB_ADR_I == ADR_CTRL && WB_SEL_I[0]) begin
                global_irq_enable_q <= WB_DAT_I[0];
            end
            if (WB_ADR_I == ADR_EN) begin
                irq_enable_reg_q <= merge(irq_enable_reg_q);
            end
            if (WB_ADR_I == ADR_PRIO) begin
                irq_priority_reg_q <= merge(irq_priority_reg_q);
            end
            if (WB_ADR_I == ADR_MASK && WB_SEL_I[0]) begin
                mask_q <= WB_DAT_I[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source events

    logic [1:0] pin_lvl; // Filtered pin levels, active low
    logic [1:0] pin_prev_q; // Previous filtered level
    logic [N_SRC-1:0] hw_set; // Flag set requests this cycle
    logic [N_SRC-1:0] auto_clr; // Flags cleared by vectoring this cycle

    // Pins are asynchronous; three flops keep metastability off the edge logic
    tlic_sync #(.W(2), .RST_VAL(1'b1)) u_sync (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .d_i(EXT_INT_N_I),
        .q_o(pin_lvl)
    );

    // Remember the filtered pins to find falling edges
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_prev_q <= 2'b11;
        end else begin
            pin_prev_q <= pin_lvl;
        end
    end

    // Peripheral pulses plus pin falling edges, regardless of enables
    always_comb begin
        hw_set = SRC_SET_I; // RL1 RL2
        hw_set[SRC_EXT0] = SRC_SET_I[SRC_EXT0] | (pin_prev_q[0] & ~pin_lvl[0]); // RL1
        hw_set[SRC_EXT1] = SRC_SET_I[SRC_EXT1] | (pin_prev_q[1] & ~pin_lvl[1]); // RL1
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration

    logic hi_any; // Some high-level request
    logic lo_any; // Some low-level request
    logic [3:0] hi_idx; // Winning high source
    logic [3:0] lo_idx; // Winning low source
    logic boundary; // Instruction boundary where a call may start
    logic take_hi; // High request may be taken now
    logic take_lo; // Low request may be taken now
    logic take; // Vector call issued this cycle
    logic [3:0] take_idx; // Source being vectored

    tlic_pick #(.W(N_SRC)) u_pick_hi (
        .req_i(req_q & irq_priority_reg_q),
        .any_o(hi_any),
        .idx_o(hi_idx)
    );

    tlic_pick #(.W(N_SRC)) u_pick_lo (
        .req_i(req_q & ~irq_priority_reg_q),
        .any_o(lo_any),
        .idx_o(lo_idx)
    );

    // Sample and gate every cycle; this register is the detect cycle
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            req_q <= '0;
        end else if (global_irq_enable_q) begin
            req_q <= pend_q & irq_enable_reg_q; // RL14 RL6 RL5
        end else begin
            req_q <= '0; // RL7
        end
    end

    // The return boundary itself never vectors, so one more
    // instruction always runs before re-entry.
    assign boundary = CORE_INSTR_DONE_I & ~CORE_RETURN_FROM_INTERRUPT_I; // RL9 RL15
    // High may preempt low; nothing preempts high
    assign take_hi = hi_any & ~insvc_q[1]; // RL12
    assign take_lo = lo_any & ~(|insvc_q); // RL15
    assign take = boundary & (take_hi | take_lo); // RL3 RL16
    assign take_idx = take_hi ? hi_idx : lo_idx; // RL13
    // Only sources in the auto-clear set lose their flag on vectoring
    assign auto_clr = take ? (AUTOCLR_MASK[N_SRC-1:0] & (N_SRC'(1) << take_idx)) : '0;

    // Pending flags: software write, auto-clear, then hardware set wins
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pend_q <= '0;
        end else if (wr_fire && WB_ADR_I == ADR_PEND) begin
            pend_q <= (merge(pend_q) & ~auto_clr) | hw_set; // RL10
        end else begin
            pend_q <= (pend_q & ~auto_clr) | hw_set; // RL8
        end
    end

    // In-service markers: set on call, top one cleared on return
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            insvc_q <= 2'b00;
        end else if (take) begin
            insvc_q[take_hi] <= 1'b1; // RL17
        end else if (CORE_RETURN_FROM_INTERRUPT_I) begin
            if (insvc_q[1]) begin
                insvc_q[1] <= 1'b0; // RL17 RL4
            end else begin
                insvc_q[0] <= 1'b0; // RL17 RL4
            end
        end
    end

    // Call pulse and vector; the core spends its own cycles on the call
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CALL_O <= 1'b0;
            VECTOR_O <= VEC_BASE;
        end else begin
            CALL_O <= take; // RL3
            if (take) begin
                VECTOR_O <= VEC_BASE + 16'(VEC_STEP * take_idx); // RL3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status and interrupt output

    logic [2:0] ev; // Events this cycle

    // Preempt counts only when a high call lands on a running low routine
    assign ev = {take & take_hi & insvc_q[0], CORE_RETURN_FROM_INTERRUPT_I & (|insvc_q), take};

    // Sticky bits; a read clears them but a same-cycle event survives
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stat_q <= 3'h0;
        end else if (rd_fire && WB_ADR_I == ADR_STAT) begin
            stat_q <= ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    // Level output, one cycle behind the status so it stays a flop
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Every check runs on the system clock and sleeps during reset
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // High-level decision at a boundary
    sequence s_take_hi;
        take && take_hi;
    endsequence

    // Call pulse standing with the expected vector
    sequence s_call_out(logic [15:0] v);
        CALL_O && VECTOR_O == v;
    endsequence

    // Requests exist only if the gate was open a cycle ago
    chk_global_gate: assert property (take |-> $past(global_irq_enable_q)) // RL7
        else $error("call taken while global enable was low");

    // Gate closed: the request register empties at the next edge
    chk_gate_off: assert property (!global_irq_enable_q |=> req_q == '0) // RL7
        else $error("request kept while global enable was low");

    // A decision is followed by that source's vector
    chk_call_vector: assert property ( // RL3
        take |=> s_call_out(VEC_BASE + 16'(VEC_STEP * $past(take_idx))))
        else $error("call pulse or vector wrong after take");

    // A return boundary is never a call boundary
    chk_return_from_interrupt_nocall: assert property (CORE_RETURN_FROM_INTERRUPT_I |=> !CALL_O) // RL9
        else $error("call issued at a return boundary");

    // No call at all while high is in service
    chk_high_nopreempt: assert property (insvc_q[1] |=> !CALL_O) // RL12
        else $error("running high routine was preempted");

    // A routine runs and no high request waits: no call
    chk_low_blocked: assert property ( // RL15
        (|insvc_q) && (req_q & irq_priority_reg_q) == '0 |=> !CALL_O)
        else $error("request called over a running routine");

    // An eligible high request means the winner is high
    chk_level_order: assert property ( // RL13
        take && (req_q & irq_priority_reg_q) != '0 && !insvc_q[1]
        |-> irq_priority_reg_q[take_idx])
        else $error("low request won over eligible high request");

    // Requests only from enabled sources under the gate
    chk_req_enabled: assert property ( // RL5
        req_q != '0 |-> $past(global_irq_enable_q) && ((req_q & ~$past(irq_enable_reg_q)) == '0))
        else $error("request raised for a disabled source");

    // Auto-clear flags drop unless a new event lands
    chk_autoclr_flag: assert property ( // RL8
        take && AUTOCLR_MASK[take_idx] && !hw_set[take_idx] |=> !pend_q[$past(take_idx)])
        else $error("auto-clear flag survived vectoring");

    // High vectoring marks high in service as the call goes out
    chk_insvc_mark: assert property (s_take_hi |=> insvc_q[1] && CALL_O) // RL17
        else $error("high in-service marker not set on call");

    // Return with only low in service leaves none in service
    chk_retire_low: assert property ( // RL17 RL4
        CORE_RETURN_FROM_INTERRUPT_I && insvc_q == 2'b01 |=> insvc_q == 2'b00)
        else $error("low in-service marker kept after return");

    // Software set survives unless auto-clear hits the same flag
    chk_sw_pend: assert property ( // RL10
        wr_fire && WB_ADR_I == ADR_PEND && WB_SEL_I[0] && WB_DAT_I[0] && !(take && auto_clr[0])
        |=> pend_q[0])
        else $error("software set of a pending flag lost");

    // A peripheral pulse on source 1 sets its flag, enabled or not
    chk_flag_sets: assert property (hw_set[1] |=> pend_q[1]) // RL2
        else $error("hardware event did not set its flag");

    // A filtered falling edge on pin 0 sets its flag
    chk_pin_flag: assert property (hw_set[SRC_EXT0] |=> pend_q[SRC_EXT0]) // RL1
        else $error("pin edge did not set its flag");
endmodule // tlic_ctrl
`default_nettype wire

// ==== verilog/tlic_pkg.sv ====
// Constants for the two-level interrupt controller: map, resets, vectors.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
// Function
// [RL1] Source conditions set their pending flags
// [RL2] Flags set even while source disabled
// [RL3] Enabled pending flag calls its fixed vector
// [RL4] Return resumes the interrupted instruction stream
// [RL5] Disabled flags never cause vectoring
// [RL6] Source enables count only under global enable
// [RL7] Global enable low blocks every source
// [RL8] Some flags auto-clear on vectoring, others software
// [RL9] Flag still set after return re-requests
// [RL10] Software may set flags to request
// [RL11] Priority bits reset to low level
// [RL12] High preempts low, high never preempted
// [RL13] Higher level first, then fixed order
// [RL14] Requests sampled every cycle, five-cycle response
// [RL15] Equal or higher running routine delays requests
// [RL16] On exit highest pending request wins
// [RL17] One in-service marker per priority level
package tlic_pkg;
    localparam int NSRC = 15; // Sources in fixed order, index 0 wins ties
    localparam int VEC_W = 16; // Code address width
    localparam logic [15:0] VEC_BASE = 16'h0003; // Vector of source 0
    localparam int VEC_STEP = 8; // Address step between vectors
    localparam int SRC_EXT0 = 0; // Pin interrupt 0 feeds this source
    localparam int SRC_EXT1 = 2; // Pin interrupt 1 feeds this source
    localparam logic [14:0] AUTOCLR_MASK = 15'h000f; // Flags cleared on vectoring
    localparam logic [14:0] PRIO_RST = 15'h0000; // All sources low after reset
    localparam logic [14:0] EN_RST = 15'h0000; // All sources disabled after reset
    localparam logic [2:0] MASK_RST = 3'h0; // Event mask after reset
    localparam int CALL_CYC = 4; // Cycles the core spends on the long call
    localparam int DETECT_CYC = 1; // Cycles to sample and decode
    localparam int RESP_MIN_CYC = DETECT_CYC + CALL_CYC; // Fastest response
    // Register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00; // Bit 0: global enable
    localparam logic [7:0] ADR_EN = 8'h04; // Per-source enables
    localparam logic [7:0] ADR_PRIO = 8'h08; // Per-source level, 1 = high
    localparam logic [7:0] ADR_PEND = 8'h0c; // Pending flags, read/write
    localparam logic [7:0] ADR_SVC = 8'h10; // In-service markers, read only
    localparam logic [7:0] ADR_STAT = 8'h14; // Event status, cleared on read
    localparam logic [7:0] ADR_MASK = 8'h18; // Event mask
    localparam logic [7:0] ADR_REQ = 8'h1c; // Eligible requests, read only
    // Event status bits
    localparam int EV_CALL = 0; // A vector call was issued
    localparam int EV_RET = 1; // A return from interrupt completed
    localparam int EV_PREEMPT = 2; // A high routine preempted a low one
endpackage

// ==== verilog/tlic_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module tlic_sync #(
    parameter int W = 2,
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q; // First stage, read only by the second
    logic [W-1:0] s2_q; // Second stage
    logic [W-1:0] s3_q; // Third stage

    // Shift chain, then accept a bit once two stages agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= {W{RST_VAL}};
            s2_q <= {W{RST_VAL}};
            s3_q <= {W{RST_VAL}};
            q_o <= {W{RST_VAL}};
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // tlic_sync
`default_nettype wire

// ==== verilog/tlic_pick.sv ====
// Fixed-order picker: lowest index among set requests wins.
// Purely combinational; W must not exceed 16.
`timescale 1ns/100ps
`default_nettype none
module tlic_pick #(
    parameter int W = 15
) (
    input wire logic [W-1:0] req_i,
    output logic any_o,
    output logic [3:0] idx_o
);
    // Scan from the top so the lowest index is written last
    always_comb begin
        any_o = |req_i;
        idx_o = 4'h0;
        for (int i = W - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                idx_o = 4'(i); // RL13
            end
        end
    end
endmodule // tlic_pick
`default_nettype wire

// ==== tb/tlic_core_model.sv ====
// Core sequencer stand-in: instruction boundaries, return boundaries, long calls.
// Assumes the controller's clock; gap_i sets the instruction length in cycles.
`timescale 1ns/100ps
`default_nettype none
module tlic_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic call_i,
    input wire logic ret_req_i,
    input wire logic [3:0] gap_i,
    output logic done_o,
    output logic return_from_interrupt_o
);
    logic [3:0] cnt_q; // Cycles left in this instruction
    logic done_q; // Boundary this cycle
    logic return_from_interrupt_q; // Boundary ends a return
    logic ret_q; // Return wanted at next boundary
    ////////////////////////////////////////////////////////////////////
    // The cycle that carries a call is not a boundary: the core is busy.
    // Limitation: a return that meets a call cycle is dropped.
    assign done_o = done_q & ~call_i;
    assign return_from_interrupt_o = return_from_interrupt_q & ~call_i;
    // Instruction timing; a call holds off boundaries for four cycles
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h1;
            done_q <= 1'b0;
            return_from_interrupt_q <= 1'b0;
            ret_q <= 1'b0;
        end else if (call_i) begin
            cnt_q <= 4'h4;
            done_q <= 1'b0;
            return_from_interrupt_q <= 1'b0;
            ret_q <= ret_q | ret_req_i;
        end else if (cnt_q <= 4'h1) begin
            cnt_q <= gap_i;
            done_q <= 1'b1;
            return_from_interrupt_q <= ret_q | ret_req_i;
            ret_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q - 4'h1;
            done_q <= 1'b0;
            return_from_interrupt_q <= 1'b0;
            ret_q <= ret_q | ret_req_i;
        end
    end
endmodule // tlic_core_model
`default_nettype wire

// ==== tb/test_two_level_interrupt_controller.sv ====
// Self-checking bench for the interrupt controller and a core stand-in.
// Assumes the Wishbone map and call timing of the controller's package.
`timescale 1ns/100ps
`default_nettype none
module test_two_level_interrupt_controller;
    import tlic_pkg::*;
    logic clk, rst_n, cyc, stb, we, ack, call, irq, done, return_from_interrupt, ret_req;
    logic [7:0] adr;
    logic [3:0] sel, gap;
    logic [31:0] wdat, rdat, q;
    logic [14:0] src;
    logic [1:0] ext_n;
    logic [15:0] vec;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    tlic_ctrl u_tlic_ctrl (.SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .SRC_SET_I(src), .EXT_INT_N_I(ext_n),
        .CORE_INSTR_DONE_I(done), .CORE_RETURN_FROM_INTERRUPT_I(return_from_interrupt), .CALL_O(call), .VECTOR_O(vec),
        .IRQ_O(irq));
    tlic_core_model u_tlic_core_model (.clk_i(clk), .rst_n_i(rst_n), .call_i(call),
        .ret_req_i(ret_req), .gap_i(gap), .done_o(done), .return_from_interrupt_o(return_from_interrupt));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // One classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'h3};
        @(posedge clk);
        while (ack !== 1'b1 && n < 9) begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        chk("ack", 32'h1, 32'(ack));
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
        wb(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask
    function automatic logic [15:0] vv(input int i);
        return VEC_BASE + 16'(VEC_STEP * i);
    endfunction
    // Waits for a call; ne < 0 means none allowed, ne > 0 the exact edge count
    task automatic wcall(input int ne, input logic [15:0] ev, input string s);
        int n;
        n = 1;
        @(posedge clk);
        while (call !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (ne < 0) chk(s, 32'h0, 32'(call));
        else chk(s, 32'(ev), call === 1'b1 ? 32'(vec) : 32'hdead);
        if (ne > 0) chk(s, 32'(ne), 32'(n));
    endtask
    task automatic pulse(input logic [14:0] m);
        src <= m;
        @(posedge clk);
        src <= 15'h0;
    endtask
    task automatic ret();
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("vector", 32'(VEC_BASE), 32'(vec));
        rd(ADR_PRIO, 32'h0, "prio");
        rd(ADR_EN, 32'h0, "enable");
        rd(ADR_SVC, 32'h0, "in service");
        wb(1'b1, 8'h20, 32'hffff);
        rd(8'h20, 32'h0, "unmapped");
        wb(1'b1, ADR_PRIO, 32'h7fff);
        rd(ADR_PRIO, 32'h7fff, "prio rw");
        wb(1'b1, ADR_PRIO, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_enable();
        wb(1'b1, ADR_CTRL, 32'h1);
        pulse(15'h20);
        wcall(-1, 16'h0, "disabled");
        rd(ADR_PEND, 32'h20, "flag while disabled");
        wb(1'b1, ADR_CTRL, 32'h0);
        wb(1'b1, ADR_EN, 32'h20);
        wcall(-1, 16'h0, "global off");
        wb(1'b1, ADR_CTRL, 32'h1);
        wcall(0, vv(5), "global on");
        rd(ADR_PEND, 32'h20, "flag kept");
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        wcall(-1, 16'h0, "after return");
        wb(1'b1, ADR_EN, 32'h40);
        pulse(15'h40);
        wcall(3, vv(6), "latency");
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        $display("test enable done");
    endtask
    task automatic t_swset();
        wb(1'b1, ADR_EN, 32'h202);
        wb(1'b1, ADR_PEND, 32'h200);
        wcall(0, vv(9), "software flag");
        rd(ADR_PEND, 32'h200, "not auto cleared");
        ret();
        wcall(3, vv(9), "flag left set");
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        wb(1'b1, ADR_PEND, 32'h2);
        wcall(0, vv(1), "auto flag");
        rd(ADR_PEND, 32'h0, "auto cleared");
        ret();
        $display("test software flag done");
    endtask
    task automatic t_prio();
        gap <= 4'h5;
        wb(1'b1, ADR_EN, 32'h88);
        pulse(15'h88);
        wcall(0, vv(3), "tie low");
        ret();
        wcall(0, vv(7), "next pending");
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        wb(1'b1, ADR_PRIO, 32'h80);
        pulse(15'h88);
        wcall(0, vv(7), "high first");
        wb(1'b1, ADR_PEND, 32'h8);
        ret();
        wcall(0, vv(3), "low after high");
        ret();
        gap <= 4'h1;
        $display("test priority done");
    endtask
    task automatic t_preempt();
        wb(1'b1, ADR_EN, 32'h150);
        wb(1'b1, ADR_PRIO, 32'h140);
        pulse(15'h10);
        wcall(0, vv(4), "low call");
        wcall(-1, 16'h0, "low blocks low");
        pulse(15'h40);
        wcall(0, vv(6), "high preempts");
        rd(ADR_SVC, 32'h3, "both markers");
        pulse(15'h100);
        wcall(-1, 16'h0, "high kept");
        wb(1'b1, ADR_PEND, 32'h110);
        ret();
        wcall(3, vv(8), "high after return");
        wb(1'b1, ADR_PEND, 32'h10);
        ret();
        wcall(-1, 16'h0, "low in service");
        rd(ADR_SVC, 32'h1, "low marker");
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        wcall(-1, 16'h0, "idle");
        rd(ADR_SVC, 32'h0, "markers clear");
        $display("test preempt done");
    endtask
    task automatic t_irq();
        wb(1'b0, ADR_STAT, 32'h0);
        wb(1'b1, ADR_MASK, 32'h1);
        wb(1'b1, ADR_EN, 32'h400);
        pulse(15'h400);
        wcall(0, vv(10), "irq source");
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, 32'(irq));
        rd(ADR_STAT, 32'h1, "status");
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        wb(1'b1, ADR_PEND, 32'h0);
        ret();
        repeat (3) @(posedge clk);
        chk("irq masked", 32'h0, 32'(irq));
        wb(1'b1, ADR_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, 32'(irq));
        rd(ADR_STAT, 32'h2, "return status");
        $display("test irq done");
    endtask
    task automatic t_pin();
        wb(1'b1, ADR_EN, 32'h5);
        ext_n <= 2'b10;
        wcall(0, vv(0), "pin zero");
        ext_n <= 2'b11;
        ret();
        ext_n <= 2'b01;
        wcall(0, vv(2), "pin one");
        ext_n <= 2'b11;
        rd(ADR_PEND, 32'h0, "pin flags");
        ret();
        $display("test pins done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, adr, wdat, sel, src, ret_req} <= '0;
        ext_n <= 2'b11;
        gap <= 4'h1;
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_enable();
        t_swset();
        t_prio();
        t_preempt();
        t_irq();
        t_pin();
        print_verdict();
    end
endmodule // test_two_level_interrupt_controller
`default_nettype wire
